// *** rtl/lpdh_params.svh ***
// Constants for the low power debug handshake block
`ifndef LPDH_PARAMS_SVH
`define LPDH_PARAMS_SVH
`define LPDH_CFG_WIDTH       16
`define LPDH_BIT_LP_DEBUG_EN 0
`define LPDH_BIT_TCO_EN      1
`define LPDH_BIT_TCO_DIV_LO  2
`define LPDH_BIT_STOP_SYNC   8
`define LPDH_CFG_RESET       16'h0000
`define LPDH_DIV_RESET       2'h0
`define LPDH_DIV_CNT_WIDTH   3
`endif

// *** rtl/lpdh_pkg.sv ***
// Types for the low power debug handshake block
`default_nettype none
package lpdh_pkg;
  typedef enum logic [2:0] {
    LPDH_RUN,
    LPDH_ENTRY_SYNC,
    LPDH_LOW_POWER,
    LPDH_WAKE_WAIT,
    LPDH_STANDBY
  } lpdh_state_t;

  typedef struct packed {
    logic       write;
    logic [15:0] data;
  } lpdh_dbg_wr_t;

  typedef struct packed {
    lpdh_state_t state;
    logic        lp_debug_en;
    logic        tco_en;
    logic [1:0]  tco_div;
    logic        stop_sync;
    logic [2:0]  div_cnt;
    logic        tco;
    logic        tdo_o;
    logic        tdo_oe;
    logic        clk_gate;
    logic        resume;
    logic        entry_done;
    logic        pd_reset;
    logic [15:0] rd_data;
  } lpdh_reg_t;
endpackage : lpdh_pkg
`default_nettype wire

// *** rtl/lpdh_top.sv ***
// Low power debug handshake: debugger-only port config, trace clock, stop sync
//
// Notes on behaviour
// - Config controls reachable only through the debugger port, never the memory map.
// - With low-power debug enabled, debug survives exit from low-power mode, but not from standby.
// - Enabled low-power exit waits for the debugger handshake before finishing.
// - Trace clock output enable switches the clock toward the debugger.
// - Two-bit divider picks system clock over 1, 2, 4 or 8; 1 at reset; the trace clock toggles each cycle at 1, so it runs at over 2, 4, 8 or 16.
// - Software low-power request starts entry, sets stop sync, and pauses.
// - After stop sync cleared, entry completes, clock stops, test data out held high.
// - Timer or pin wake-up drives test data out low to signal the debugger.
// - Device sees stop sync set, releases test data out, clears flag, resumes.
// - Stop sync flag sits at bit 8 of the debug port config register.
// - Standby exit resets all but power domain 0 registers.
// - Standby drops the debugger link; resynchronisation follows exit.
`include "lpdh_params.svh"
`default_nettype none
module lpdh_top (
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  input  wire lpdh_pkg::lpdh_dbg_wr_t      dbg_wr,
  input  wire logic                        mode_req_low_power,
  input  wire logic                        mode_req_standby,
  input  wire logic                        timer_wakeup_source,
  input  wire logic                        pin_wakeup,
  output logic [`LPDH_CFG_WIDTH-1:0]       debug_port_config_reg,
  output logic                             trace_clock_out,
  output logic                             tdo_out,
  output logic                             tdo_oe,
  output logic                             system_clock_gate,
  output logic                             software_resume,
  output logic                             entry_complete,
  output logic                             pd_nonzero_reset
);
  logic [1:0]          rst_sync_q;
  logic                rst_n_int;
  lpdh_pkg::lpdh_reg_t r_q;
  lpdh_pkg::lpdh_reg_t r_d;

  logic                wake;
  logic                cfg_write;
  logic                sync_clear_req;
  logic                sync_set_req;

  logic [3:0]          div_span;
  logic [2:0]          div_max;
  logic                div_hit;

  // Two-flop release so every field leaves reset on the same edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n_int = rst_sync_q[1];

  assign wake = timer_wakeup_source | pin_wakeup;

  // Debug link is unpowered in standby, so writes there are lost
  assign cfg_write      = dbg_wr.write && (r_q.state != lpdh_pkg::LPDH_STANDBY);
  assign sync_clear_req = cfg_write && !dbg_wr.data[`LPDH_BIT_STOP_SYNC];
  assign sync_set_req   = cfg_write && dbg_wr.data[`LPDH_BIT_STOP_SYNC];

  // Compare with >= so a smaller divider written mid-count still wraps
  assign div_span = 4'h1 << r_q.tco_div;
  assign div_max  = div_span[2:0] - 3'h1;
  assign div_hit  = (r_q.div_cnt >= div_max);

  always_comb begin
    r_d = r_q;
    r_d.resume = 1'h0;
    r_d.pd_reset = 1'h0;

    // Config only via debugger write port, no memory-mapped path
    if (cfg_write) begin
      r_d.lp_debug_en = dbg_wr.data[`LPDH_BIT_LP_DEBUG_EN];
      r_d.tco_en      = dbg_wr.data[`LPDH_BIT_TCO_EN];
      r_d.tco_div     = dbg_wr.data[`LPDH_BIT_TCO_DIV_LO +: 2];
    end

    // Divide by 1 toggles each cycle: a flop output cannot follow the clock itself
    if (!r_q.tco_en) begin
      r_d.tco = 1'h0;
      r_d.div_cnt = 3'h0;
    end else if (r_q.tco_div == `LPDH_DIV_RESET) begin
      r_d.tco = ~r_q.tco;
    end else if (div_hit) begin
      r_d.tco = ~r_q.tco;
      r_d.div_cnt = 3'h0;
    end else begin
      r_d.div_cnt = r_q.div_cnt + 3'h1;
    end

    case (r_q.state)
      lpdh_pkg::LPDH_RUN: begin
        r_d.tdo_o = 1'h0;
        r_d.clk_gate = 1'h0;
        r_d.entry_done = 1'h0;
        if (mode_req_standby) begin
          // Standby drops the link: no handshake kept
          r_d.state = lpdh_pkg::LPDH_STANDBY;
          r_d.clk_gate = 1'h1;
          r_d.entry_done = 1'h1;
        end else if (mode_req_low_power && r_q.lp_debug_en) begin
          r_d.stop_sync = 1'h1;
          r_d.state = lpdh_pkg::LPDH_ENTRY_SYNC;
        end else if (mode_req_low_power) begin
          // No debugger to wait for, so straight into low power
          r_d.state = lpdh_pkg::LPDH_LOW_POWER;
          r_d.clk_gate = 1'h1;
          r_d.entry_done = 1'h1;
        end
      end

      lpdh_pkg::LPDH_ENTRY_SYNC: begin
        // No timeout: a silent debugger stalls entry on purpose
        r_d.tdo_o = 1'h0;
        r_d.clk_gate = 1'h0;
        r_d.entry_done = 1'h0;
        if (sync_clear_req) begin
          r_d.stop_sync = 1'h0;
          r_d.state = lpdh_pkg::LPDH_LOW_POWER;
          r_d.clk_gate = 1'h1;
          r_d.tdo_o = 1'h1;
          r_d.entry_done = 1'h1;
        end
      end

      lpdh_pkg::LPDH_LOW_POWER: begin
        // Wake is a level, so a held wake source is harmless here
        r_d.clk_gate = 1'h1;
        r_d.entry_done = 1'h1;
        if (wake) begin
          r_d.clk_gate = 1'h0;
          r_d.entry_done = 1'h0;
          if (r_q.lp_debug_en) begin
            r_d.tdo_o = 1'h0;
            r_d.state = lpdh_pkg::LPDH_WAKE_WAIT;
          end else begin
            r_d.resume = 1'h1;
            r_d.state = lpdh_pkg::LPDH_RUN;
          end
        end
      end

      lpdh_pkg::LPDH_WAKE_WAIT: begin
        // Debugger answers by setting stop sync; flag seen then cleared
        r_d.tdo_o = 1'h0;
        r_d.clk_gate = 1'h0;
        r_d.entry_done = 1'h0;
        if (sync_set_req) begin
          r_d.stop_sync = 1'h0;
          r_d.resume = 1'h1;
          r_d.state = lpdh_pkg::LPDH_RUN;
        end
      end

      lpdh_pkg::LPDH_STANDBY: begin
        r_d.tdo_o = 1'h0;
        r_d.clk_gate = 1'h1;
        r_d.entry_done = 1'h1;
        if (wake) begin
          // Non-PD0 state reset; debug config lives outside PD0 here
          r_d = '0;
          r_d.state = lpdh_pkg::LPDH_RUN;
          r_d.pd_reset = 1'h1;
        end
      end

      default: begin
        r_d.state = lpdh_pkg::LPDH_RUN;
        r_d.stop_sync = 1'h0;
      end
    endcase

    // Pin stays driven except while the link is powered down
    r_d.tdo_oe = (r_d.state != lpdh_pkg::LPDH_STANDBY);

    // Readback built from next state so it matches the fields exactly
    r_d.rd_data = `LPDH_CFG_RESET;
    r_d.rd_data[`LPDH_BIT_LP_DEBUG_EN] = r_d.lp_debug_en;
    r_d.rd_data[`LPDH_BIT_TCO_EN] = r_d.tco_en;
    r_d.rd_data[`LPDH_BIT_TCO_DIV_LO +: 2] = r_d.tco_div;
    r_d.rd_data[`LPDH_BIT_STOP_SYNC] = r_d.stop_sync;
  end

  // Low clock enable freezes every field, outputs included
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // Every output is a field of the state register
  assign debug_port_config_reg = r_q.rd_data;
  assign trace_clock_out       = r_q.tco;
  assign tdo_out               = r_q.tdo_o;
  assign tdo_oe                = r_q.tdo_oe;
  assign system_clock_gate     = r_q.clk_gate;
  assign software_resume       = r_q.resume;
  assign entry_complete        = r_q.entry_done;
  assign pd_nonzero_reset      = r_q.pd_reset;
endmodule // lpdh_top
`default_nettype wire

// *** dv/lpdh_sva.sv ***
// Port checker for the low power debug handshake
`default_nettype none
module lpdh_sva (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  input wire lpdh_pkg::lpdh_dbg_wr_t dbg_wr,
  input wire logic                   mode_req_low_power,
  input wire logic                   timer_wakeup_source,
  input wire logic                   pin_wakeup,
  input wire logic [15:0]            debug_port_config_reg,
  input wire logic                   tdo_out,
  input wire logic                   system_clock_gate,
  input wire logic                   software_resume,
  input wire logic                   entry_complete,
  input wire logic                   pd_nonzero_reset
);
  wire en = debug_port_config_reg[0];
  wire sy = debug_port_config_reg[8];
  wire gt = system_clock_gate;
  wire ws = dbg_wr.write && clk_en;
  wire wk = timer_wakeup_source || pin_wakeup;
  wire go = clk_en && mode_req_low_power && !sy && !entry_complete && !tdo_out;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Wake seen while gated, then the pin drops
  sequence s_wake;
    clk_en && en && gt && wk ##1 !tdo_out;
  endsequence
  a_entry_sets_sync: assert property (go && en |=> sy && !gt)
    else $error("no stop sync");
  a_sync_pauses: assert property (clk_en && sy && !entry_complete && !ws |=> sy && !gt)
    else $error("no pause");
  a_clear_enters: assert property (sy && !entry_complete && ws && !dbg_wr.data[8]
    |=> gt && tdo_out && entry_complete) else $error("no entry");
  a_wake_low: assert property (clk_en && en && gt && tdo_out && wk |=> !tdo_out && !gt)
    else $error("no wake");
  a_resume_after: assert property (s_wake ##[0:40] (ws && dbg_wr.data[8])
    |=> software_resume && !sy) else $error("no resume");
  a_no_early: assert property (s_wake ##1 (clk_en && !dbg_wr.write) [*2]
    |-> !software_resume) else $error("early resume");
  a_skip_sync: assert property (go && !en |=> entry_complete && gt && !sy)
    else $error("no skip");
  a_standby_clear: assert property (pd_nonzero_reset && !ws |=> !debug_port_config_reg)
    else $error("not cleared");
endmodule // lpdh_sva
bind lpdh_top lpdh_sva u_sva (.*);
`default_nettype wire

// *** dv/lpdh_dbg_model.sv ***
// Debugger model on the debug port
`default_nettype none
module lpdh_dbg_model (
  input wire logic                  clock,
  input wire logic [15:0]           cfg,
  input wire logic                  tdo,
  input wire logic [3:0]            lag,
  output var lpdh_pkg::lpdh_dbg_wr_t wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'b0;
  initial begin
    wr = '0;
    forever begin
      @(posedge clock);
      // Save on stop sync, restore on a falling pin; one flip serves both
      if (cfg[8] || (prev && !tdo)) begin
        repeat (lag) @(posedge clock);
        wr <= {1'h1, cfg ^ 16'h0100};
        @(posedge clock);
        wr <= {1'h0, ~cfg};
      end
      prev = tdo;
    end
  end
endmodule // lpdh_dbg_model
`default_nettype wire

// *** dv/tb_low_power_debug_handshake.sv ***
// Bench for the low power debug handshake
`default_nettype none
module tb_low_power_debug_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset_n = 1'b0, clk_en = 1'b1, pv;
  logic [3:0] rq = 4'h0, lag = 4'h0;
  wire mode_req_low_power = rq[0], mode_req_standby = rq[1];
  wire timer_wakeup_source = rq[2], pin_wakeup = rq[3];
  logic [15:0] debug_port_config_reg;
  logic trace_clock_out, tdo_out, tdo_oe, system_clock_gate;
  logic software_resume, entry_complete, pd_nonzero_reset;
  int n_errors = 0, num_checks = 0, k, t, c;
  lpdh_pkg::lpdh_dbg_wr_t dbg_wr, mw, tw = '0;
  wire [3:0] st = {pd_nonzero_reset, software_resume, entry_complete, debug_port_config_reg[8]};
  assign dbg_wr = tw.write ? tw : mw;
  always #4 clock = ~clock;
  lpdh_top DUT (
    .clock                 (clock),
    .reset_n               (reset_n),
    .clk_en                (clk_en),
    .dbg_wr                (dbg_wr),
    .mode_req_low_power    (mode_req_low_power),
    .mode_req_standby      (mode_req_standby),
    .timer_wakeup_source   (timer_wakeup_source),
    .pin_wakeup            (pin_wakeup),
    .debug_port_config_reg (debug_port_config_reg),
    .trace_clock_out       (trace_clock_out),
    .tdo_out               (tdo_out),
    .tdo_oe                (tdo_oe),
    .system_clock_gate     (system_clock_gate),
    .software_resume       (software_resume),
    .entry_complete        (entry_complete),
    .pd_nonzero_reset      (pd_nonzero_reset)
  );
  lpdh_dbg_model u_dbg (.clock(clock), .cfg(debug_port_config_reg), .tdo(tdo_out),
    .lag(lag), .wr(mw));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge clock) tw <= {1'b1, d};
    @(posedge clock) tw <= {1'b0, ~d};
  endtask
  task automatic pulse(input int i);
    @(posedge clock) rq[i] <= 1'b1;
    @(posedge clock) rq[i] <= 1'b0;
  endtask
  task automatic await(input int i);
    for (k = 0; k < 40 && st[i] !== 1'b1; k++) @(negedge clock);
    chk(st[i], 16'h0001);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20us;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(negedge clock);
    chk(debug_port_config_reg, 16'h0000);
    chk(16'(tdo_oe), 16'h0001);
    for (t = 0; t < 2; t++) begin
      lag <= 4'(6 * t);
      wr(16'h0001);
      pulse(0);
      await(0);
      await(1);
      chk({system_clock_gate, tdo_out}, 16'h0003);
      pulse(2 + t);
      @(negedge clock) chk(tdo_out, 16'h0000);
      await(2);
      chk(st, 16'h0004);
      $display("handshake %0d done", t);
    end
    wr(16'h0000);
    pulse(0);
    @(negedge clock) chk(st, 16'h0002);
    pulse(3);
    await(2);
    $display("no debug done");
    for (t = 0; t < 5; t++) begin
      wr(t < 4 ? 16'(4 * t + 2) : 16'h0000);
      repeat (20) @(negedge clock);
      c = 0;
      pv = trace_clock_out;
      repeat (64) begin
        @(negedge clock);
        c += int'(trace_clock_out !== pv);
        pv = trace_clock_out;
      end
      chk(16'(c), t < 4 ? 16'h0040 >> t : 16'h0000);
    end
    $display("trace done");
    @(posedge clock) clk_en <= 1'h0;
    wr(16'h0001);
    @(negedge clock) chk(debug_port_config_reg, 16'h0000);
    @(posedge clock) clk_en <= 1'h1;
    $display("freeze done");
    wr(16'h000E);
    pulse(1);
    @(negedge clock) chk({tdo_oe, system_clock_gate, entry_complete}, 16'h0003);
    wr(16'h0001);
    @(negedge clock) chk(debug_port_config_reg, 16'h000E);
    pulse(2);
    await(3);
    @(negedge clock) chk(debug_port_config_reg, 16'h0000);
    $display("standby done");
    conclude();
  end
endmodule // tb_low_power_debug_handshake
`default_nettype wire
